// >>> bench/vcic_master.sv
// Bus master model: register reads, writes and interrupt acknowledges
`timescale 1ns/1ps
module vcic_master
(
    // Clock
    input wire logic clk,
    // Bus side
    output vcic_pkg::vcic_bus_s bus,
    output logic iack,
    output logic [2:0] iack_level,
    input wire logic [15:0] rdata
);
    logic [5:0] am_sel = vcic_pkg::AM_A24_SUP;

    initial
    begin
        bus = '0;
        iack = 1'b0;
        iack_level = 3'h0;
    end

    //====================
    // Accesses
    // Released address and data lines are inverted so a stale value cannot pass; the modifier is kept
    task automatic access(input logic w, input logic [23:0] a, input logic [15:0] d, output logic [15:0] q);
        @(posedge clk);
        bus <= '{addr: a, am: am_sel, wdata: d, wr: w, rd: !w};
        @(posedge clk);
        bus <= '{addr: ~a, am: am_sel, wdata: ~d, wr: 1'b0, rd: 1'b0};
        @(negedge clk);
        q = rdata;
    endtask

    task automatic ack(input logic [2:0] lvl);
        @(posedge clk);
        iack <= 1'b1;
        iack_level <= lvl;
        @(posedge clk);
        iack <= 1'b0;
        iack_level <= ~lvl;
        @(negedge clk);
    endtask
endmodule // vcic_master

// >>> bench/vcic_top_bench.sv
// Self-checking bench of the change-of-state input controller
`timescale 1ns/1ps
module vcic_top_bench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [63:0] field_in = '0;
    vcic_pkg::vcic_strap_s strap = 13'h0400;
    vcic_pkg::vcic_bus_s bus;
    logic iack;
    logic [2:0] iack_level;
    logic [15:0] rdata;
    logic [15:0] q;
    logic [15:0] t1;
    logic [6:0] irq_req;
    logic [7:0] vec_data;
    logic vec_valid;
    logic fail_led;
    logic [15:0] cnt_exp [4] = '{16'h0001, 16'h0001, 16'h0002, 16'h0000};
    int n_mismatch = 0;
    int n_tests = 0;

    always #25 clk = ~clk;

    // Short millisecond so the timer moves within the run
    vcic_top #(.TICK_CYCLES(20)) dut (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .iack(iack),
        .iack_level(iack_level), .irq_req(irq_req), .vec_data(vec_data), .vec_valid(vec_valid),
        .strap(strap), .field_in(field_in), .fail_led(fail_led));
    vcic_master bfm (.clk(clk), .bus(bus), .iack(iack), .iack_level(iack_level), .rdata(rdata));

    //====================
    // Helpers
    function automatic logic [23:0] adr(input logic [13:0] o);
        return {10'h000, o};
    endfunction

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic rd(input logic [23:0] a, input logic [15:0] exp, input string name);
        bfm.access(1'b0, a, 16'h0000, q);
        chk(name, exp, q);
    endtask

    task automatic wr(input logic [23:0] a, input logic [15:0] d);
        bfm.access(1'b1, a, d, q);
    endtask

    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic boot;
        rst_n <= 1'b0;
        repeat (5) @(posedge clk);
        chk("fail_led", 16'h0001, {15'h0000, fail_led});
        rst_n <= 1'b1;
        // Self-test must finish before the first access
        repeat (200) @(posedge clk);
        rd(adr(vcic_pkg::OFS_CTL), 16'h001b, "ctl");
        rd(adr(vcic_pkg::OFS_COUNT + 14'h0004), 16'h0000, "count2");
        rd(adr(vcic_pkg::OFS_LOG_TIME), 16'h0000, "log_clear");
    endtask

    //====================
    // Tests
    initial
    begin
        boot();
        rd(adr(vcic_pkg::OFS_VEC), 16'h0000, "vec");
        rd(adr(vcic_pkg::OFS_EDGE), 16'h0000, "edge");
        rd(adr(vcic_pkg::OFS_TIME), 16'h0000, "time");
        rd(adr(vcic_pkg::OFS_LOG_MAX), 16'h0000, "log_max");
        rd(adr(vcic_pkg::OFS_LOG_CNT), 16'h0000, "log_cnt");
        rd(24'h004000, 16'h0000, "off_base");
        bfm.am_sel = vcic_pkg::AM_A16_SUP;
        rd(adr(vcic_pkg::OFS_CTL), 16'h0000, "short_space");
        bfm.am_sel = 6'h09;
        rd(adr(vcic_pkg::OFS_CTL), 16'h0000, "bad_am");
        bfm.am_sel = vcic_pkg::AM_A24_NP;
        rd(adr(vcic_pkg::OFS_CTL), 16'h001b, "nonpriv");
        bfm.am_sel = vcic_pkg::AM_A24_SUP;
        wr(adr(vcic_pkg::OFS_VEC), 16'h00a5);
        wr(adr(vcic_pkg::OFS_EDGE), 16'h0039);
        wr(adr(vcic_pkg::OFS_COS_SEL), 16'h000f);
        wr(adr(vcic_pkg::OFS_LOG_MAX), 16'h0003);
        wr(adr(vcic_pkg::OFS_CTL), 16'h0164);
        bfm.access(1'b0, adr(vcic_pkg::OFS_TIME), 16'h0000, t1);
        // Strobes exactly 100 cycles apart
        repeat (98) @(posedge clk);
        rd(adr(vcic_pkg::OFS_TIME), t1 + 16'h0005, "tick");
        wr(adr(vcic_pkg::OFS_CTL), 16'h0364);
        rd(adr(vcic_pkg::OFS_TIME), 16'h0000, "time_clear");
        @(posedge clk);
        field_in <= 64'h0000_0000_0000_000f;
        repeat (10) @(posedge clk);
        chk("irq", 16'h0004, {9'h000, irq_req});
        bfm.ack(3'h2);
        chk("vvalid_other", 16'h0000, {15'h0000, vec_valid});
        chk("irq_kept", 16'h0004, {9'h000, irq_req});
        bfm.ack(3'h3);
        chk("vvalid", 16'h0001, {15'h0000, vec_valid});
        chk("vec_data", 16'h00a5, {8'h00, vec_data});
        chk("irq_drop", 16'h0000, {9'h000, irq_req});
        @(posedge clk);
        field_in <= '0;
        repeat (10) @(posedge clk);
        for (int c = 0; c < 4; c++)
            rd(adr(vcic_pkg::OFS_COUNT + 14'(2 * c)), cnt_exp[c], "count");
        rd(adr(vcic_pkg::OFS_LOG_CNT), 16'h0003, "log_full");
        rd(adr(vcic_pkg::OFS_LOG_CHAN), 16'h0001, "log_chan");
        // Straps pass two flops, so let them settle before each access
        @(posedge clk);
        strap <= 13'h0000;
        repeat (3) @(posedge clk);
        rd(adr(vcic_pkg::OFS_VEC), 16'h0000, "np_strap_sup");
        bfm.am_sel = vcic_pkg::AM_A24_NP;
        rd(adr(vcic_pkg::OFS_VEC), 16'h00a5, "np_strap_np");
        @(posedge clk);
        strap <= 13'h1400;
        bfm.am_sel = vcic_pkg::AM_A16_SUP;
        repeat (3) @(posedge clk);
        rd(adr(vcic_pkg::OFS_VEC), 16'h00a5, "short_strap");
        @(posedge clk);
        strap <= 13'h0400;
        bfm.am_sel = vcic_pkg::AM_A24_SUP;
        boot();
        report_and_stop();
    end

    initial
    begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        report_and_stop();
    end
endmodule // vcic_top_bench

// >>> rtl/vcic_pkg.sv
// Constants, types and register map of the change-of-state input controller
//==========================================================================
// Behaviour
// - Each of 64 channels detects rising, falling, both, or no edges.
// - Each detected event may be logged with a 16-bit millisecond time tag.
// - A bus write clears the time tag, which then counts again from zero.
// - Every detected event increments that channel's own event counter until it reaches 65535.
// - Interrupts go out on a software-chosen level; acknowledge returns one vector byte.
// - The acknowledge that reads the vector also withdraws the request, unless a new event raises it in the same cycle.
// - A strap, not software, chooses standard or short address space.
// - Address modifiers accept nonprivileged, supervisory, or both, per straps.
// - Self-test runs after every reset and then sets the complete bit.
// - Reset turns fail indicator on, masks interrupts, clears flags, enters test mode.
// - Reset clears vector, selections, edge settings and all event counters.
// - Reset loads the time tag with zero and holds it stopped.
// - Reset clears the log limit and the current log count.
// - Self-test leaves test data in the log on failure, clears it on pass.
// - One strap pair selects standard (fitted) or short address decoding.
// - Two strap pairs select both privilege kinds or nonprivileged only.
// - Address bits A14 to A23 (only A14 and A15 in short space) match one strap each; fitted means zero.
// - Default straps give base zero, standard space, both privilege kinds.
// - A fitted strap reads as logic zero, an absent one as one.
// - Each event counter is 16 bits wide and holds up to 65535.
package vcic_pkg;

    localparam int CH_NUM = 64;
    localparam int CNT_W = 16;
    localparam int LOG_DEPTH = 64;
    localparam int LOG_AW = 6;
    localparam int LOG_W = 23;

    // Millisecond prescaler
    localparam int CLK_PERIOD_NS = 50;
    localparam int TICK_PERIOD_NS = 1000000;
    localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

    // Register byte offsets inside the 16 KB board window
    localparam logic [13:0] OFS_CTL = 14'h0000;
    localparam logic [13:0] OFS_VEC = 14'h0002;
    localparam logic [13:0] OFS_TIME = 14'h0004;
    localparam logic [13:0] OFS_LOG_MAX = 14'h0006;
    localparam logic [13:0] OFS_LOG_CNT = 14'h0008;
    localparam logic [13:0] OFS_LOG_IDX = 14'h000a;
    localparam logic [13:0] OFS_LOG_CHAN = 14'h000c;
    localparam logic [13:0] OFS_LOG_TIME = 14'h000e;
    localparam logic [13:0] OFS_INPUT = 14'h0020;
    localparam logic [13:0] OFS_COS_SEL = 14'h0030;
    localparam logic [13:0] OFS_CNT_SEL = 14'h0038;
    localparam logic [13:0] OFS_EDGE = 14'h0040;
    localparam logic [13:0] OFS_COUNT = 14'h0100;

    // Control and status bit positions
    localparam int CTL_FAIL = 0;
    localparam int CTL_TEST = 1;
    localparam int CTL_IRQ_EN = 2;
    localparam int CTL_ST_DONE = 3;
    localparam int CTL_ST_PASS = 4;
    localparam int CTL_LVL_LSB = 5;
    localparam int CTL_RUN = 8;
    localparam int CTL_TCLR = 9;
    localparam int CTL_FLAG = 10;

    // Published bus address modifier codes
    localparam logic [5:0] AM_A24_NP = 6'h39;
    localparam logic [5:0] AM_A24_SUP = 6'h3d;
    localparam logic [5:0] AM_A16_NP = 6'h29;
    localparam logic [5:0] AM_A16_SUP = 6'h2d;

    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [LOG_W-1:0] ST_PATTERN = 23'h5a3c96;
    localparam logic [CNT_W-1:0] CNT_NEAR_FULL = 16'hfffe;

    typedef enum logic [3:0] {
        ST_FILL = 4'b0001,
        ST_CHECK = 4'b0010,
        ST_CLEAR = 4'b0100,
        ST_DONE = 4'b1000
    } vcic_st_e;

    typedef struct packed {
        logic [23:0] addr;
        logic [5:0] am;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } vcic_bus_s;

    // Straps read low when the plug is fitted
    typedef struct packed {
        logic std_n;
        logic any_n;
        logic np_n;
        logic [9:0] base_n;
    } vcic_strap_s;

    typedef struct packed {
        logic [12:0] strap1;
        logic [12:0] strap2;
        logic [CH_NUM-1:0] sync1;
        logic [CH_NUM-1:0] sync2;
        logic [CH_NUM-1:0] prev;
        logic [CH_NUM-1:0] pend;
        logic [2*CH_NUM-1:0] edge_sel;
        logic [CH_NUM-1:0] cos_sel;
        logic [CH_NUM-1:0] cnt_sel;
        logic [CH_NUM-1:0][CNT_W-1:0] count;
        logic fail_led;
        logic test_mode;
        logic irq_en;
        logic flag;
        logic [2:0] irq_lvl;
        logic [7:0] irq_vec;
        logic irq_pend;
        logic [7:0] vec_out;
        logic vec_valid;
        logic timer_run;
        logic [14:0] presc;
        logic [15:0] time_tag;
        logic [6:0] log_max;
        logic [6:0] log_cnt;
        logic [LOG_AW-1:0] log_idx;
        logic [15:0] rdata;
        vcic_st_e st;
        logic [LOG_AW-1:0] st_addr;
        logic st_pass;
        logic st_done;
    } vcic_state_s;

endpackage

// >>> rtl/vcic_top.sv
// Change-of-state input controller: detection, counting, event log, interrupter and bus slave
//
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
module vcic_top
#(
    parameter int TICK_CYCLES = vcic_pkg::TICK_CYCLES
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register access
    input vcic_pkg::vcic_bus_s bus,
    output logic [15:0] rdata,
    // Interrupt request and acknowledge
    input wire logic iack,
    input wire logic [2:0] iack_level,
    output logic [6:0] irq_req,
    output logic [7:0] vec_data,
    output logic vec_valid,
    // Straps and field pins
    input vcic_pkg::vcic_strap_s strap,
    input wire logic [63:0] field_in,
    output logic fail_led
);

    //==========================================================================
    // Helpers
    function automatic logic in_block(input logic [13:0] off, input logic [13:0] base, input int unsigned n);
        in_block = (off >= base) && ({18'h0, off} < {18'h0, base} + 32'(2 * n));
    endfunction

    function automatic logic edge_hit(input logic [1:0] sel, input logic was, input logic now);
        edge_hit = (sel[0] && !was && now) || (sel[1] && was && !now);
    endfunction

    vcic_pkg::vcic_state_s s_reg;
    vcic_pkg::vcic_state_s s_next;
    logic [vcic_pkg::LOG_W-1:0] log_mem [vcic_pkg::LOG_DEPTH];
    logic [vcic_pkg::CH_NUM-1:0] evt;
    logic mem_we;
    logic [vcic_pkg::LOG_AW-1:0] mem_addr;
    logic [vcic_pkg::LOG_W-1:0] mem_data;
    logic sel;
    logic am_ok;
    logic win_ok;
    logic [13:0] off;
    logic ack_hit;
    logic cause;
    logic log_room;
    logic detect_on;

    //==========================================================================
    // Edge detection on the synchronised copies
    assign detect_on = s_reg.st_done && !s_reg.test_mode;
    genvar gc;
    generate
        for (gc = 0; gc < vcic_pkg::CH_NUM; gc++)
        begin : g_edge
            assign evt[gc] = detect_on
                && edge_hit(s_reg.edge_sel[2*gc +: 2], s_reg.prev[gc], s_reg.sync2[gc]);
        end
    endgenerate

    //==========================================================================
    // Address and modifier decode
    always_comb
    begin
        logic std_mode;
        logic np_only;
        logic both;
        logic is_np;
        logic is_sup;
        std_mode = !s_reg.strap2[12];
        np_only = !s_reg.strap2[10];
        both = !s_reg.strap2[11];
        is_np = std_mode ? (bus.am == vcic_pkg::AM_A24_NP) : (bus.am == vcic_pkg::AM_A16_NP);
        is_sup = std_mode ? (bus.am == vcic_pkg::AM_A24_SUP) : (bus.am == vcic_pkg::AM_A16_SUP);
        // Nonprivileged strap wins; no plug at all leaves supervisory only
        if (np_only)
        begin
            am_ok = is_np;
        end
        else if (both)
        begin
            am_ok = is_np || is_sup;
        end
        else
        begin
            am_ok = is_sup;
        end
        // Short space only has A14 and A15 above the window
        if (std_mode)
        begin
            win_ok = bus.addr[23:14] == s_reg.strap2[9:0];
        end
        else
        begin
            win_ok = (bus.addr[15:14] == s_reg.strap2[1:0]) && (bus.addr[23:16] == 8'h00);
        end
    end

    assign sel = am_ok && win_ok && s_reg.st_done;
    assign off = bus.addr[13:0];
    assign ack_hit = iack && s_reg.irq_pend && (iack_level == s_reg.irq_lvl);
    assign log_room = s_reg.log_cnt < s_reg.log_max;

    //==========================================================================
    // Next state
    always_comb
    begin
        logic found;
        logic [5:0] first;
        logic [3:0] ridx;
        s_next = s_reg;
        found = 1'b0;
        first = 6'h00;
        ridx = 4'h0;
        mem_we = 1'b0;
        mem_addr = s_reg.st_addr;
        mem_data = '0;
        cause = 1'b0;
        s_next.strap1 = strap;
        s_next.strap2 = s_reg.strap1;
        s_next.sync1 = field_in;
        s_next.sync2 = s_reg.sync1;
        s_next.prev = s_reg.sync2;
        s_next.vec_valid = 1'b0;
        s_next.rdata = 16'h0000;

        // Self-test walk over the log memory
        case (s_reg.st)
            vcic_pkg::ST_FILL:
            begin
                mem_we = 1'b1;
                mem_data = vcic_pkg::ST_PATTERN ^ {17'h0, s_reg.st_addr};
                s_next.st_addr = s_reg.st_addr + 6'h01;
                if (s_reg.st_addr == 6'h3f)
                begin
                    s_next.st = vcic_pkg::ST_CHECK;
                end
            end
            vcic_pkg::ST_CHECK:
            begin
                if (log_mem[s_reg.st_addr] != (vcic_pkg::ST_PATTERN ^ {17'h0, s_reg.st_addr}))
                begin
                    s_next.st_pass = 1'b0;
                end
                s_next.st_addr = s_reg.st_addr + 6'h01;
                if (s_reg.st_addr == 6'h3f)
                begin
                    s_next.st = s_next.st_pass ? vcic_pkg::ST_CLEAR : vcic_pkg::ST_DONE;
                    s_next.st_done = !s_next.st_pass;
                end
            end
            vcic_pkg::ST_CLEAR:
            begin
                mem_we = 1'b1;
                s_next.st_addr = s_reg.st_addr + 6'h01;
                if (s_reg.st_addr == 6'h3f)
                begin
                    s_next.st = vcic_pkg::ST_DONE;
                    s_next.st_done = 1'b1;
                end
            end
            vcic_pkg::ST_DONE:
            begin
                s_next.st_done = 1'b1;
            end
            default:
            begin
                s_next.st = vcic_pkg::ST_DONE;
            end
        endcase

        // Millisecond time tag
        if (s_reg.timer_run)
        begin
            if (s_reg.presc == 15'(TICK_CYCLES - 1))
            begin
                s_next.presc = 15'h0000;
                s_next.time_tag = s_reg.time_tag + 16'h0001;
            end
            else
            begin
                s_next.presc = s_reg.presc + 15'h0001;
            end
        end

        // Register reads, data one cycle later
        if (bus.rd && sel)
        begin
            if (off == vcic_pkg::OFS_CTL)
            begin
                s_next.rdata = {5'h00, s_reg.flag, 1'b0, s_reg.timer_run, s_reg.irq_lvl, s_reg.st_pass,
                    s_reg.st_done, s_reg.irq_en, s_reg.test_mode, s_reg.fail_led};
            end
            else if (off == vcic_pkg::OFS_VEC)
            begin
                s_next.rdata = {8'h00, s_reg.irq_vec};
            end
            else if (off == vcic_pkg::OFS_TIME)
            begin
                s_next.rdata = s_reg.time_tag;
            end
            else if (off == vcic_pkg::OFS_LOG_MAX)
            begin
                s_next.rdata = {9'h000, s_reg.log_max};
            end
            else if (off == vcic_pkg::OFS_LOG_CNT)
            begin
                s_next.rdata = {9'h000, s_reg.log_cnt};
            end
            else if (off == vcic_pkg::OFS_LOG_IDX)
            begin
                s_next.rdata = {10'h000, s_reg.log_idx};
            end
            else if (off == vcic_pkg::OFS_LOG_CHAN)
            begin
                s_next.rdata = {9'h000, log_mem[s_reg.log_idx][22:16]};
            end
            else if (off == vcic_pkg::OFS_LOG_TIME)
            begin
                s_next.rdata = log_mem[s_reg.log_idx][15:0];
            end
            else if (in_block(off, vcic_pkg::OFS_INPUT, 4))
            begin
                s_next.rdata = s_reg.sync2[16*off[2:1] +: 16];
            end
            else if (in_block(off, vcic_pkg::OFS_COS_SEL, 4))
            begin
                s_next.rdata = s_reg.cos_sel[16*off[2:1] +: 16];
            end
            else if (in_block(off, vcic_pkg::OFS_CNT_SEL, 4))
            begin
                s_next.rdata = s_reg.cnt_sel[16*off[2:1] +: 16];
            end
            else if (in_block(off, vcic_pkg::OFS_EDGE, 8))
            begin
                s_next.rdata = s_reg.edge_sel[16*off[3:1] +: 16];
            end
            else if (in_block(off, vcic_pkg::OFS_COUNT, 64))
            begin
                s_next.rdata = s_reg.count[off[6:1]];
            end
        end

        // Register writes
        if (bus.wr && sel)
        begin
            ridx = {1'b0, off[3:1]};
            if (off == vcic_pkg::OFS_CTL)
            begin
                s_next.fail_led = bus.wdata[vcic_pkg::CTL_FAIL];
                s_next.test_mode = bus.wdata[vcic_pkg::CTL_TEST];
                s_next.irq_en = bus.wdata[vcic_pkg::CTL_IRQ_EN];
                s_next.irq_lvl = bus.wdata[vcic_pkg::CTL_LVL_LSB +: 3];
                s_next.timer_run = bus.wdata[vcic_pkg::CTL_RUN];
                if (bus.wdata[vcic_pkg::CTL_TCLR])
                begin
                    s_next.time_tag = 16'h0000;
                    s_next.presc = 15'h0000;
                end
                if (bus.wdata[vcic_pkg::CTL_FLAG])
                begin
                    s_next.flag = 1'b0;
                end
            end
            else if (off == vcic_pkg::OFS_VEC)
            begin
                s_next.irq_vec = bus.wdata[7:0];
            end
            else if (off == vcic_pkg::OFS_LOG_MAX)
            begin
                s_next.log_max = (bus.wdata[6:0] > 7'(vcic_pkg::LOG_DEPTH)) ? 7'(vcic_pkg::LOG_DEPTH) : bus.wdata[6:0];
            end
            else if (off == vcic_pkg::OFS_LOG_CNT)
            begin
                s_next.log_cnt = 7'h00;
            end
            else if (off == vcic_pkg::OFS_LOG_IDX)
            begin
                s_next.log_idx = bus.wdata[5:0];
            end
            else if (in_block(off, vcic_pkg::OFS_COS_SEL, 4))
            begin
                s_next.cos_sel[16*ridx[1:0] +: 16] = bus.wdata;
            end
            else if (in_block(off, vcic_pkg::OFS_CNT_SEL, 4))
            begin
                s_next.cnt_sel[16*ridx[1:0] +: 16] = bus.wdata;
            end
            else if (in_block(off, vcic_pkg::OFS_EDGE, 8))
            begin
                s_next.edge_sel[16*ridx[2:0] +: 16] = bus.wdata;
            end
            else if (in_block(off, vcic_pkg::OFS_COUNT, 64))
            begin
                s_next.count[off[6:1]] = 16'h0000;
            end
        end

        // Counting after any clear, so an event in the clear cycle survives
        for (int i = 0; i < vcic_pkg::CH_NUM; i++)
        begin
            if (evt[i])
            begin
                if (s_next.count[i] != 16'hffff)
                begin
                    s_next.count[i] = s_next.count[i] + 16'h0001;
                end
                if (s_reg.cos_sel[i] || (s_reg.cnt_sel[i] && s_reg.count[i] == vcic_pkg::CNT_NEAR_FULL))
                begin
                    cause = 1'b1;
                end
            end
        end

        // Event log: one entry per cycle, lowest pending channel first
        for (int i = vcic_pkg::CH_NUM - 1; i >= 0; i--)
        begin
            if (s_reg.pend[i])
            begin
                found = 1'b1;
                first = 6'(i);
            end
        end
        if (found && s_reg.st == vcic_pkg::ST_DONE && log_room)
        begin
            mem_we = 1'b1;
            mem_addr = s_reg.log_cnt[5:0];
            mem_data = {first, s_reg.sync2[first], s_reg.time_tag};
            s_next.log_cnt = s_reg.log_cnt + 7'h01;
            s_next.pend[first] = 1'b0;
        end
        // A full log drops new events instead of queueing stale ones
        s_next.pend = log_room ? (s_next.pend | evt) : '0;

        // Interrupter: new event wins over the acknowledge in the same cycle
        if (ack_hit)
        begin
            s_next.irq_pend = 1'b0;
            s_next.vec_out = s_reg.irq_vec;
            s_next.vec_valid = 1'b1;
        end
        if (cause)
        begin
            s_next.flag = 1'b1;
            if (s_reg.irq_en && s_reg.irq_lvl != 3'h0)
            begin
                s_next.irq_pend = 1'b1;
            end
        end
    end

    //==========================================================================
    // Registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_reg <= '0;
            s_reg.fail_led <= 1'b1;
            s_reg.test_mode <= 1'b1;
            s_reg.st <= vcic_pkg::ST_FILL;
            s_reg.st_pass <= 1'b1;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // Log memory has no reset; the self-test fills it and clears it on pass
    always_ff @(posedge clk)
    begin
        if (mem_we)
        begin
            log_mem[mem_addr] <= mem_data;
        end
    end

    //==========================================================================
    // Outputs
    assign rdata = s_reg.rdata;
    assign vec_data = s_reg.vec_out;
    assign vec_valid = s_reg.vec_valid;
    assign fail_led = s_reg.fail_led;
    assign irq_req = s_reg.irq_pend ? (7'h01 << (s_reg.irq_lvl - 3'h1)) : 7'h00;

    //==========================================================================
    // Assertions
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_ack_cycle;
        ack_hit && !cause;
    endsequence

    sequence s_vector_out;
        vec_valid && !s_reg.irq_pend;
    endsequence

    AST_EDGE_COUNT: assert property (evt[0] && s_reg.count[0] < 16'hfffe && !(bus.wr && sel && off == vcic_pkg::OFS_COUNT)
        |=> s_reg.count[0] == $past(s_reg.count[0]) + 16'h0001) else $error("event count missed");
    AST_COUNT_SAT: assert property (s_reg.count[0] == 16'hffff && !(bus.wr && sel)
        |=> s_reg.count[0] == 16'hffff) else $error("event count wrapped");
    AST_TIME_CLEAR: assert property (bus.wr && sel && off == vcic_pkg::OFS_CTL && bus.wdata[vcic_pkg::CTL_TCLR]
        |=> s_reg.time_tag == 16'h0000) else $error("time tag not cleared");
    AST_TIME_HOLD: assert property (!s_reg.timer_run && !(bus.wr && sel)
        |=> $stable(s_reg.time_tag)) else $error("stopped time tag moved");
    AST_ROAK: assert property (s_ack_cycle |=> s_vector_out ##0 vec_data == $past(s_reg.irq_vec))
        else $error("acknowledge did not release request");
    AST_IRQ_HOLD: assert property (s_reg.irq_pend && !ack_hit |=> s_reg.irq_pend && irq_req != 7'h00)
        else $error("request dropped before acknowledge");
    AST_AM_NP_ONLY: assert property (sel && !s_reg.strap2[10] |-> bus.am == vcic_pkg::AM_A24_NP
        || bus.am == vcic_pkg::AM_A16_NP) else $error("privileged access accepted");
    AST_SELF_TEST: assert property (s_reg.st == vcic_pkg::ST_FILL |-> ##[1:200] s_reg.st_done)
        else $error("self-test did not complete");
    AST_INIT_STATE: assert property (s_reg.st == vcic_pkg::ST_FILL |-> s_reg.fail_led && s_reg.test_mode
        && !s_reg.irq_en && s_reg.log_max == 7'h00) else $error("init state wrong");
    AST_SYNC_EDGE: assert property (evt[0] |=> !evt[0] || s_reg.sync2[0] != $past(s_reg.sync2[0]))
        else $error("one edge gave two events");
    AST_LOG_LIMIT: assert property (!log_room && !(bus.wr && sel) |=> s_reg.log_cnt == $past(s_reg.log_cnt))
        else $error("log overran its limit");

endmodule // vcic_top
